// File: hw/rba_pkg.sv
package rba_pkg;
	// ****************************************
	// alarm field layout
	// ****************************************
	localparam int  ALM_FIELDS    = 6;
	localparam int  ALM_EN_BIT    = 7;
	localparam int  FLD_SEC       = 0;
	localparam int  FLD_MIN       = 1;
	localparam int  FLD_HOUR      = 2;
	localparam int  FLD_DATE      = 3;
	localparam int  FLD_MONTH     = 4;
	localparam int  FLD_WDAY      = 5;
	// interrupt control bit positions
	localparam int  ICR_ALM0_EN   = 5;
	localparam int  ICR_PULSE_SEL = 7;
	// ****************************************
	// reset values
	// ****************************************
	localparam logic RST_SW_SEL   = 1'h1;
	localparam logic RST_INHIBIT  = 1'h0;
	localparam logic [7:0] RST_ALM = 8'h00;
	// ****************************************
	// timing
	// ****************************************
	localparam int  CLK_MHZ       = 100;
	localparam int  IRQ_PULSE_NS  = 100;
	localparam int  IRQ_PULSE_CYC = (IRQ_PULSE_NS * CLK_MHZ + 999) / 1000;
	localparam int  SYNC_STAGES   = 3;
endpackage : rba_pkg

// File: hw/rba_gate_if.sv
`timescale 1ns/1ps
interface rba_gate_if;
	logic supply_ok;
	logic above_bat;
	logic bat_above_rst;
	logic on_battery;
	logic bus_allow;
	logic nv_allow;
	logic out_allow;
	modport gate (input supply_ok, above_bat, bat_above_rst, on_battery,
		output bus_allow, nv_allow, out_allow);
	modport user (output supply_ok, above_bat, bat_above_rst, on_battery,
		input bus_allow, nv_allow, out_allow);
endinterface : rba_gate_if

// File: hw/rba_gate.sv
`timescale 1ns/1ps
module rba_gate (
	input  wire logic mclk,
	input  wire logic rst_n_sync,
	input  wire logic backup_bus_inhibit,
	input  wire logic supply_switch_select,
	rba_gate_if.gate  g
);
	// ****************************************
	// power-mode gating
	// ****************************************
	always_comb begin
		g.bus_allow = 1'b0;
		g.nv_allow  = 1'b0;
		g.out_allow = 1'b0;
		if (g.supply_ok) begin
			case ({backup_bus_inhibit, supply_switch_select})
			2'b00: begin
				g.bus_allow = !g.on_battery;
				g.nv_allow  = !g.on_battery;
				g.out_allow = !g.on_battery;
			end
			2'b01: begin
				g.bus_allow = !g.on_battery || g.bat_above_rst;
				g.nv_allow  = g.bus_allow;
				g.out_allow = 1'b1;
			end
			2'b10: begin
				g.bus_allow = !g.on_battery;
				g.nv_allow  = !g.on_battery;
				g.out_allow = 1'b1;
			end
			default: begin
				g.bus_allow = g.above_bat;
				g.nv_allow  = g.above_bat;
				g.out_allow = 1'b1;
			end
			endcase
		end else begin
			// legacy mode loses the output with the supply; inhibit modes keep it
			g.out_allow = backup_bus_inhibit;
		end
	end

	a_no_bus_low: assert property (@(posedge mclk) disable iff (!rst_n_sync)
		!g.supply_ok |-> !g.bus_allow) else $error("bus allowed below reset level");
	a_mode_d_bus: assert property (@(posedge mclk) disable iff (!rst_n_sync)
		(backup_bus_inhibit && supply_switch_select && g.supply_ok)
		|-> g.bus_allow == g.above_bat) else $error("mode d bus gating wrong");
	a_mode_c_out: assert property (@(posedge mclk) disable iff (!rst_n_sync)
		(backup_bus_inhibit && !supply_switch_select) |-> g.out_allow)
		else $error("output dropped in mode c");
	a_mode_a_nv: assert property (@(posedge mclk) disable iff (!rst_n_sync)
		(!backup_bus_inhibit && !supply_switch_select && g.on_battery) |-> !g.nv_allow)
		else $error("nv access in standard backup");
	a_mode_b_bus: assert property (@(posedge mclk) disable iff (!rst_n_sync)
		(!backup_bus_inhibit && supply_switch_select && g.on_battery && g.supply_ok)
		|-> g.bus_allow == g.bat_above_rst) else $error("legacy bus gating wrong");
	a_std_bus: assert property (@(posedge mclk) disable iff (!rst_n_sync)
		(!supply_switch_select && g.on_battery) |-> !g.bus_allow)
		else $error("bus allowed in standard backup");
	a_mode_b_out: assert property (@(posedge mclk) disable iff (!rst_n_sync)
		(!backup_bus_inhibit && supply_switch_select && !g.supply_ok) |-> !g.out_allow)
		else $error("legacy output active below reset");
endmodule : rba_gate

// File: hw/rba_top.sv
`timescale 1ns/1ps
// Contract
// - supply below reset threshold: bus response stops in every mode
// - mode 00: standard switchover, no bus or memory access on battery
// - mode 01 legacy: access on battery only while battery above reset
// - mode 10: like standard, but clock/interrupt output stays active
// - mode 11: bus only while supply above both battery and reset level
// - each alarm field: enable in bit 7, bcd value below it
// - field with enable clear is left out of the comparison
// - single mode triggers when all enabled fields match new time
// - a match sets the alarm0 status flag
// - pulsed mode, seconds 30 only: one interrupt every minute
// - pulse select is control bit 7, used together with alarm enable
// - pulsed triggers keep coming even if the flag is never cleared
// - power-up defaults to legacy backup behaviour
module rba_top #(
	parameter int FIELDS = rba_pkg::ALM_FIELDS
) (
	input  wire logic        mclk,
	input  wire logic        rst_b,
	input  wire logic        sec_tick,
	input  wire logic [7:0]  time_sec,
	input  wire logic [7:0]  time_min,
	input  wire logic [7:0]  time_hour,
	input  wire logic [7:0]  time_date,
	input  wire logic [7:0]  time_month,
	input  wire logic [7:0]  time_wday,
	input  wire logic [7:0]  alarm0_seconds,
	input  wire logic [7:0]  alarm0_minutes,
	input  wire logic [7:0]  alarm0_hours,
	input  wire logic [7:0]  alarm0_date,
	input  wire logic [7:0]  alarm0_month,
	input  wire logic [7:0]  alarm0_weekday,
	input  wire logic [7:0]  int_ctrl,
	input  wire logic        cfg_wr,
	input  wire logic        cfg_inhibit,
	input  wire logic        cfg_switch_sel,
	input  wire logic        flag_clr,
	input  wire logic        vdd_above_rst,
	input  wire logic        vdd_above_bat,
	input  wire logic        bat_above_rst,
	input  wire logic        on_battery,
	output logic             bus_enable,
	output logic             nv_enable,
	output logic             irq_out_enable,
	output logic             alarm0_flag,
	output logic             irq_b,
	output logic             backup_bus_inhibit,
	output logic             supply_switch_select
);
	// ****************************************
	// reset release
	// ****************************************
	logic [1:0] rst_sh_reg;
	logic       rst_n;
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) rst_sh_reg <= 2'h0;
		else        rst_sh_reg <= {rst_sh_reg[0], 1'b1};
	end
	assign rst_n = rst_sh_reg[1];

	// ****************************************
	// threshold synchronisers
	// ****************************************
	// three stages; a change counts once stages two and three agree
	logic [3:0] s1_reg, s2_reg, s3_reg, flt_reg;
	logic [3:0] raw;
	assign raw = {on_battery, bat_above_rst, vdd_above_bat, vdd_above_rst};
	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++) begin : g_sync
			always_ff @(posedge mclk or negedge rst_n) begin
				if (!rst_n) begin
					s1_reg[gi]  <= 1'b0;
					s2_reg[gi]  <= 1'b0;
					s3_reg[gi]  <= 1'b0;
					flt_reg[gi] <= 1'b0;
				end else begin
					s1_reg[gi] <= raw[gi];
					s2_reg[gi] <= s1_reg[gi];
					s3_reg[gi] <= s2_reg[gi];
					if (s2_reg[gi] == s3_reg[gi]) flt_reg[gi] <= s3_reg[gi];
				end
			end
		end
	endgenerate

	// ****************************************
	// backup mode bits
	// ****************************************
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			supply_switch_select <= rba_pkg::RST_SW_SEL;
			backup_bus_inhibit   <= rba_pkg::RST_INHIBIT;
		end else if (cfg_wr) begin
			supply_switch_select <= cfg_switch_sel;
			backup_bus_inhibit   <= cfg_inhibit;
		end
	end

	rba_gate_if gif ();
	assign gif.supply_ok     = flt_reg[0];
	assign gif.above_bat     = flt_reg[1];
	assign gif.bat_above_rst = flt_reg[2];
	assign gif.on_battery    = flt_reg[3];

	rba_gate u_gate (
		.mclk                 (mclk),
		.rst_n_sync           (rst_n),
		.backup_bus_inhibit   (backup_bus_inhibit),
		.supply_switch_select (supply_switch_select),
		.g                    (gif)
	);

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			bus_enable     <= 1'b0;
			nv_enable      <= 1'b0;
			irq_out_enable <= 1'b0;
		end else begin
			bus_enable     <= gif.bus_allow;
			nv_enable      <= gif.nv_allow;
			irq_out_enable <= gif.out_allow;
		end
	end

	// ****************************************
	// alarm comparator
	// ****************************************
	logic [7:0] alm [FIELDS];
	logic [7:0] now [FIELDS];
	logic [FIELDS-1:0] fld_ok;
	assign alm[rba_pkg::FLD_SEC]   = alarm0_seconds;
	assign alm[rba_pkg::FLD_MIN]   = alarm0_minutes;
	assign alm[rba_pkg::FLD_HOUR]  = alarm0_hours;
	assign alm[rba_pkg::FLD_DATE]  = alarm0_date;
	assign alm[rba_pkg::FLD_MONTH] = alarm0_month;
	assign alm[rba_pkg::FLD_WDAY]  = alarm0_weekday;
	assign now[rba_pkg::FLD_SEC]   = time_sec;
	assign now[rba_pkg::FLD_MIN]   = time_min;
	assign now[rba_pkg::FLD_HOUR]  = time_hour;
	assign now[rba_pkg::FLD_DATE]  = time_date;
	assign now[rba_pkg::FLD_MONTH] = time_month;
	assign now[rba_pkg::FLD_WDAY]  = time_wday;

	generate
		for (gi = 0; gi < FIELDS; gi++) begin : g_cmp
			// disabled field always passes; bcd compared below the enable bit
			assign fld_ok[gi] = !alm[gi][rba_pkg::ALM_EN_BIT] ||
				(alm[gi][rba_pkg::ALM_EN_BIT-1:0] == now[gi][rba_pkg::ALM_EN_BIT-1:0]);
		end
	endgenerate

	logic alm_en, pulse_sel, tick_d_reg, hit;
	assign alm_en    = int_ctrl[rba_pkg::ICR_ALM0_EN];
	assign pulse_sel = int_ctrl[rba_pkg::ICR_PULSE_SEL];
	// sample one cycle after the tick so the advanced time is settled
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) tick_d_reg <= 1'b0;
		else        tick_d_reg <= sec_tick;
	end
	assign hit = tick_d_reg && alm_en && (&fld_ok);

	// set wins over a clear in the same cycle
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n)        alarm0_flag <= 1'b0;
		else if (hit)      alarm0_flag <= 1'b1;
		else if (flag_clr) alarm0_flag <= 1'b0;
	end

	// ****************************************
	// interrupt output
	// ****************************************
	// pulsed mode: fixed-width low pulse per hit, independent of the flag
	// single mode: level follows the flag until cleared
	localparam int PW = rba_pkg::IRQ_PULSE_CYC;
	logic [7:0] pcnt_reg;
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n)                 pcnt_reg <= 8'h00;
		else if (hit && pulse_sel)  pcnt_reg <= 8'(PW);
		else if (pcnt_reg != 8'h00) pcnt_reg <= pcnt_reg - 8'h01;
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) irq_b <= 1'b1;
		else if (pulse_sel)
			irq_b <= !((hit || pcnt_reg > 8'h01) && gif.out_allow);
		else
			irq_b <= !((hit || alarm0_flag) && gif.out_allow);
	end

	// ****************************************
	// checks
	// ****************************************
	sequence s_hit;
		tick_d_reg && alm_en && (&fld_ok);
	endsequence
	a_flag_set: assert property (@(posedge mclk) disable iff (!rst_n)
		s_hit |=> alarm0_flag) else $error("flag not set on match");
	a_no_enable: assert property (@(posedge mclk) disable iff (!rst_n)
		(!alm_en && !alarm0_flag && !flag_clr) |=> !alarm0_flag)
		else $error("flag set without alarm enable");
	a_skip_field: assert property (@(posedge mclk) disable iff (!rst_n)
		(tick_d_reg && alm_en && !alarm0_flag && !flag_clr && alarm0_seconds == 8'h00
		&& (&fld_ok[FIELDS-1:1])) |=> alarm0_flag)
		else $error("disabled seconds blocked match");
	a_tick_only: assert property (@(posedge mclk) disable iff (!rst_n)
		(!tick_d_reg && !alarm0_flag) |=> !alarm0_flag)
		else $error("flag set off the tick");
	a_pulse_irq: assert property (@(posedge mclk) disable iff (!rst_n)
		(s_hit and (pulse_sel && gif.out_allow)) |=> !irq_b)
		else $error("pulsed interrupt missing");
	a_pulse_repeat: assert property (@(posedge mclk) disable iff (!rst_n)
		(s_hit and (alarm0_flag && pulse_sel && gif.out_allow)) |=> !irq_b ##1 !irq_b)
		else $error("pulse lost while flag set");
	a_bus_sync: assert property (@(posedge mclk) disable iff (!rst_n)
		!flt_reg[0] |=> !bus_enable) else $error("bus enabled below reset");
endmodule : rba_top

// File: bench/rba_host.sv
`timescale 1ns/1ps
module rba_host (
	input  wire logic       mclk,
	output logic [5:0][7:0] fld,
	output logic [7:0]      ctrl
);
	initial begin
		fld = '0;
		ctrl = 8'h00;
	end
	// fields and control land together, so enable never runs ahead of values
	task automatic load_alarm(input logic [5:0][7:0] f, input logic [7:0] c);
		@(negedge mclk);
		fld = f;
		ctrl = c;
	endtask : load_alarm
endmodule : rba_host

// File: bench/tb_top.sv
`timescale 1ns/1ps
module tb_top;
	logic            mclk = 1'h0;
	logic            rst_b = 1'h0;
	logic            sec_tick = 1'h0;
	logic [5:0][7:0] tm = '0;
	logic [5:0][7:0] fld;
	logic [7:0]      ctrl;
	logic            cfg_wr = 1'h0;
	logic [1:0]      cfg = 2'h0;
	logic            flag_clr = 1'h0;
	logic [3:0]      thr = 4'h8;
	logic [2:0]      en;
	logic            flag, irq_b, inh, sel, exp_flag;
	logic [5:0][7:0] t2;
	int              n_mismatch = 0;
	int              tests_run = 0;
	int              seed = 32'h2a00;
	always #5 mclk = ~mclk;
	rba_host host (.mclk(mclk), .fld(fld), .ctrl(ctrl));
	rba_top dut (.mclk(mclk), .rst_b(rst_b), .sec_tick(sec_tick),
		.time_sec(tm[0]), .time_min(tm[1]), .time_hour(tm[2]),
		.time_date(tm[3]), .time_month(tm[4]), .time_wday(tm[5]),
		.alarm0_seconds(fld[0]), .alarm0_minutes(fld[1]), .alarm0_hours(fld[2]),
		.alarm0_date(fld[3]), .alarm0_month(fld[4]), .alarm0_weekday(fld[5]),
		.int_ctrl(ctrl), .cfg_wr(cfg_wr), .cfg_inhibit(cfg[1]), .cfg_switch_sel(cfg[0]),
		.flag_clr(flag_clr), .vdd_above_rst(thr[3]), .vdd_above_bat(thr[2]),
		.bat_above_rst(thr[1]), .on_battery(thr[0]), .bus_enable(en[2]),
		.nv_enable(en[1]), .irq_out_enable(en[0]), .alarm0_flag(flag), .irq_b(irq_b),
		.backup_bus_inhibit(inh), .supply_switch_select(sel));
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		tests_run++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic final_report();
		$display("checks %0d mismatches %0d", tests_run, n_mismatch);
		if (n_mismatch == 0 && tests_run > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask : final_report
	task automatic cyc(input int n);
		repeat (n) @(negedge mclk);
	endtask : cyc
	// ****************************************
	// reference model
	// ****************************************
	function automatic logic [2:0] gexp(input logic [1:0] m, input logic [3:0] t);
		if (!t[3]) return {2'h0, m[1]};
		case (m)
			2'h0: return {3{!t[0]}};
			2'h1: return {{2{!t[0] | t[1]}}, 1'h1};
			2'h2: return {{2{!t[0]}}, 1'h1};
			default: return {{2{t[2]}}, 1'h1};
		endcase
	endfunction : gexp
	function automatic logic hit(input logic [5:0][7:0] t);
		hit = ctrl[5];
		for (int i = 0; i < 6; i++)
			if (fld[i][7] && fld[i][6:0] != t[i][6:0]) hit = 1'h0;
	endfunction : hit
	task automatic set_mode(input logic [1:0] m);
		@(negedge mclk);
		cfg = m;
		cfg_wr = 1'h1;
		@(negedge mclk);
		cfg_wr = 1'h0;
		cyc(1);
		chk(8'({inh, sel}), 8'(m));
	endtask : set_mode
	task automatic step(input logic [5:0][7:0] f, input logic [7:0] c, input logic [5:0][7:0] t);
		host.load_alarm(f, c);
		@(negedge mclk);
		tm = t;
		sec_tick = 1'h1;
		@(negedge mclk);
		sec_tick = 1'h0;
		cyc(2);
		if (hit(t)) exp_flag = 1'h1;
		chk(8'(flag), 8'(exp_flag));
		chk(8'(irq_b), 8'(c[7] ? !hit(t) : !exp_flag));
		if (c[7] && hit(t)) begin
			cyc(7);
			chk(8'(irq_b), 8'h00);
			cyc(4);
			chk(8'(irq_b), 8'h01);
		end
	endtask : step
	initial begin
		cyc(12);
		rst_b = 1'h1;
		cyc(4);
		chk(8'({inh, sel}), 8'h01);
		for (int m = 0; m < 4; m++) begin
			set_mode(m[1:0]);
			repeat (16) begin
				thr = 4'($random(seed));
				cyc(8);
				chk(8'(en), 8'(gexp(m[1:0], thr)));
			end
		end
		// one-cycle dip on the supply flag must be filtered out
		thr = 4'hc;
		cyc(8);
		thr = 4'h4;
		cyc(1);
		thr = 4'hc;
		cyc(8);
		chk(8'(en), 8'(gexp(2'h3, 4'hc)));
		$display("gating test done");
		set_mode(2'h1);
		thr = 4'h8;
		exp_flag = 1'h0;
		cyc(8);
		t2 = {8'h03, 8'h01, 8'h01, 8'h11, 8'h30, 8'h00};
		step({8'h00, 8'h81, 8'h81, 8'h91, 8'hb0, 8'h00}, 8'h00, t2);
		step({8'h00, 8'h81, 8'h81, 8'h91, 8'hb0, 8'h00}, 8'h20,
			{8'h03, 8'h01, 8'h01, 8'h11, 8'h29, 8'h59});
		t2[5] = 8'($random(seed));
		step({8'h00, 8'h81, 8'h81, 8'h91, 8'hb0, 8'h00}, 8'h20, t2);
		@(negedge mclk);
		flag_clr = 1'h1;
		@(negedge mclk);
		flag_clr = 1'h0;
		cyc(1);
		exp_flag = 1'h0;
		chk(8'({flag, irq_b}), 8'h01);
		$display("single alarm test done");
		for (int i = 0; i < 3; i++) begin
			step({40'h0, 8'hb0}, 8'ha0, {24'h010101, 8'h11, 8'(i), 8'h30});
			step({40'h0, 8'hb0}, 8'ha0, {24'h010101, 8'h11, 8'(i), 8'h31});
		end
		$display("pulsed alarm test done");
		final_report();
	end
	initial begin
		#100000;
		n_mismatch++;
		final_report();
	end
endmodule : tb_top
